// [src/shift_latch_pkg.sv]
package shift_latch_pkg;

    // width of the shift chain and of the holding latch
    localparam int STAGES     = 8;
    // pin synchroniser length
    localparam int SYNC_DEPTH = 3;

    // values after reset
    localparam logic [STAGES-1:0]     RST_WORD = 8'h00;
    localparam logic [SYNC_DEPTH-1:0] RST_SYNC = 3'h0;
    localparam logic                  RST_BIT  = 1'h0;

    // field positions inside the pin group
    localparam int PIN_OE     = 3;
    localparam int PIN_STROBE = 2;
    localparam int PIN_CLK    = 1;
    localparam int PIN_DATA   = 0;
    localparam int PIN_COUNT  = 4;

    typedef struct packed {
        logic out_enable;
        logic strobe;
        logic shift_clk;
        logic serial_data;
    } pin_s;

    typedef struct packed {
        logic [PIN_COUNT-1:0][SYNC_DEPTH-1:0] sync;
        pin_s                                 filt;
        logic [STAGES-1:0]                    shift;
        logic [STAGES-1:0]                    latch;
        logic                                 last_stage;
        logic                                 cascade;
        logic [STAGES-1:0]                    par_data;
        logic [STAGES-1:0]                    par_oe;
    } state_s;

endpackage

// [src/serial_shift_latch_tristate.sv]
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1 - eight shift stages, eight latch bits
// R2 - each clock rise advances register one place
// R3 - serial input enters stage one, others shift
// R4 - seventh stage moves to last-stage output
// R5 - last-stage output chains to next device
// R6 - second cascade copies last stage on fall
// R7 - each latch bit fed by its stage
// R8 - latch holds from strobe fall while low
// R9 - strobe high makes latch transparent
// R10 - parallel outputs driven only when enabled
// R11 - controller shifts eight bits, then strobes
module serial_shift_latch_tristate (
    // clock, reset, enable
    input  wire logic                              core_clk_in,
    input  wire logic                              rstn_in,
    input  wire logic                              ce_in,
    // pins from the controller
    input  wire shift_latch_pkg::pin_s             pins_in,
    // serial cascade
    output var  logic                              last_stage_out,
    output var  logic                              serial_cascade_out,
    // three-state parallel word
    output var  logic [shift_latch_pkg::STAGES-1:0] par_data_out,
    output var  logic [shift_latch_pkg::STAGES-1:0] par_oe_out
);
    import shift_latch_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    // R1 eight stages, eight latch bits
    state_s          st_r;
    state_s          st_nxt;
    logic [PIN_COUNT-1:0] pin_vec;
    logic [PIN_COUNT-1:0] agree;
    logic            clk_rise;
    logic            clk_fall;

    assign pin_vec = pins_in;

    // a pin level counts once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_agree
            assign agree[gi] = (st_r.sync[gi][1] == st_r.sync[gi][2]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;
        clk_rise = 1'b0;
        clk_fall = 1'b0;

        // first stage feeds only the second
        for (int i = 0; i < PIN_COUNT; i++) begin
            st_nxt.sync[i] = {st_r.sync[i][1:0], pin_vec[i]};
        end
        if (agree[PIN_DATA]) begin
            st_nxt.filt.serial_data = st_r.sync[PIN_DATA][2];
        end
        if (agree[PIN_STROBE]) begin
            st_nxt.filt.strobe = st_r.sync[PIN_STROBE][2];
        end
        if (agree[PIN_OE]) begin
            st_nxt.filt.out_enable = st_r.sync[PIN_OE][2];
        end
        if (agree[PIN_CLK]) begin
            st_nxt.filt.shift_clk = st_r.sync[PIN_CLK][2];
            clk_rise = st_r.sync[PIN_CLK][2] & ~st_r.filt.shift_clk;
            clk_fall = ~st_r.sync[PIN_CLK][2] & st_r.filt.shift_clk;
        end

        // R2 advance on rise
        if (clk_rise) begin
            // R3 serial into stage one
            st_nxt.shift = {st_r.shift[STAGES-2:0], st_r.filt.serial_data};
            // R4 seventh to last stage
            st_nxt.last_stage = st_r.shift[STAGES-2];
        end

        // R6 copy on falling edge
        if (clk_fall) begin
            st_nxt.cascade = st_r.last_stage;
        end

        // R9 transparent while strobe high; R8 holds once it falls
        if (st_nxt.filt.strobe) begin
            // R7 bit-for-bit from stages
            st_nxt.latch = st_nxt.shift;
        end

        // R10 drive only when enabled
        st_nxt.par_data = st_nxt.latch;
        st_nxt.par_oe   = {STAGES{st_nxt.filt.out_enable}};
    end

    ////////////////////////////////////////////////////////////////////////

    // reset clears par_oe, so the outputs stay high-z until enabled after reset
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_r.sync       <= {PIN_COUNT{RST_SYNC}};
            st_r.filt       <= '0;
            st_r.shift      <= RST_WORD;
            st_r.latch      <= RST_WORD;
            st_r.last_stage <= RST_BIT;
            st_r.cascade    <= RST_BIT;
            st_r.par_data   <= RST_WORD;
            st_r.par_oe     <= RST_WORD;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // R5 last stage doubles as chain output
    assign last_stage_out     = st_r.last_stage;
    assign serial_cascade_out = st_r.cascade;
    assign par_data_out       = st_r.par_data;
    assign par_oe_out         = st_r.par_oe;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in || !ce_in);

    sequence s_rise;
        ce_in && clk_rise;
    endsequence

    sequence s_fall;
        ce_in && clk_fall;
    endsequence

    property p_stage_one;
        s_rise |=> st_r.shift[0] == $past(st_r.filt.serial_data);
    endproperty
    a_stage_one: assert property (p_stage_one) // R3
        else $error("stage one missed serial bit");

    property p_advance;
        s_rise |=> st_r.shift[STAGES-1:1] == $past(st_r.shift[STAGES-2:0]);
    endproperty
    a_advance: assert property (p_advance) // R2
        else $error("register did not advance");

    property p_no_rise_hold;
        !clk_rise |=> $stable(st_r.shift);
    endproperty
    a_no_rise_hold: assert property (p_no_rise_hold) // R2
        else $error("register moved without clock rise");

    property p_last;
        s_rise |=> last_stage_out == $past(st_r.shift[STAGES-2]);
    endproperty
    a_last: assert property (p_last) // R4
        else $error("last stage not loaded from seventh");

    property p_chain;
        last_stage_out == st_r.shift[STAGES-1];
    endproperty
    a_chain: assert property (p_chain) // R5
        else $error("chain output differs from last stage");

    property p_cascade;
        s_fall |=> serial_cascade_out == $past(last_stage_out);
    endproperty
    a_cascade: assert property (p_cascade) // R6
        else $error("second cascade missed falling edge");

    property p_cascade_hold;
        !clk_fall |=> $stable(serial_cascade_out);
    endproperty
    a_cascade_hold: assert property (p_cascade_hold) // R6
        else $error("second cascade changed off falling edge");

    property p_transparent;
        st_r.filt.strobe |-> st_r.latch == st_r.shift;
    endproperty
    a_transparent: assert property (p_transparent) // R9
        else $error("latch not transparent with strobe high");

    property p_hold;
        (!st_r.filt.strobe ##1 !st_r.filt.strobe) |-> $stable(st_r.latch);
    endproperty
    a_hold: assert property (p_hold) // R8
        else $error("latch changed while strobe low");

    property p_par_data;
        ##1 par_data_out == $past(st_nxt.latch);
    endproperty
    a_par_data: assert property (p_par_data) // R7
        else $error("parallel word not from latch");

    property p_enable;
        par_oe_out == {STAGES{st_r.filt.out_enable}};
    endproperty
    a_enable: assert property (p_enable) // R10
        else $error("output enable mismatch");

endmodule

`default_nettype wire

// [verif/shift_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module shift_ctrl_model (
    // clock
    input  wire logic                  core_clk_in,
    // controller pins
    output var  shift_latch_pkg::pin_s pins_out
);
    import shift_latch_pkg::*;
    initial pins_out = '0;
    // six cycles per level, the pin filter needs four
    task automatic set_pin(input int idx, input logic lvl);
        @(negedge core_clk_in);
        pins_out[idx] = lvl;
        repeat (5) @(negedge core_clk_in);
    endtask
    task automatic shift_rise(input logic b);
        set_pin(PIN_DATA, b);
        set_pin(PIN_CLK, 1'h1);
    endtask
endmodule
`default_nettype wire

// [verif/tb_serial_shift_latch_tristate.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_serial_shift_latch_tristate;
    import shift_latch_pkg::*;
    logic              core_clk_in;
    logic              rstn_in;
    logic              ce_in;
    pin_s              pins;
    logic              last_stage;
    logic              cascade;
    logic [STAGES-1:0] par_data;
    logic [STAGES-1:0] par_oe;
    wire  [STAGES-1:0] par_pin;
    logic [STAGES-1:0] mdl;
    logic [STAGES-1:0] word;
    logic [STAGES-1:0] held;
    logic              prev;
    int                fails;
    int                total_checks;
    for (genvar g = 0; g < STAGES; g++) begin : g_pin
        assign par_pin[g] = par_oe[g] ? par_data[g] : 1'bz;
    end
    initial begin
        core_clk_in = 1'h0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    serial_shift_latch_tristate uut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .ce_in(ce_in), .pins_in(pins), .last_stage_out(last_stage),
        .serial_cascade_out(cascade), .par_data_out(par_data), .par_oe_out(par_oe));
    shift_ctrl_model ctl (.core_clk_in(core_clk_in), .pins_out(pins));
    ////////////////////////////////////////
    function automatic logic [STAGES-1:0] shift_in(input logic [STAGES-1:0] q, input logic b);
        return {q[STAGES-2:0], b};
    endfunction
    function automatic logic [STAGES-1:0] pin_exp(input logic [STAGES-1:0] w, input logic oe);
        return oe ? w : 8'hZZ;
    endfunction
    task automatic check(input string n, input logic [STAGES-1:0] e, input logic [STAGES-1:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        // twelve words take about 2400 cycles
        repeat (40000) @(posedge core_clk_in);
        fails++;
        results();
    end
    initial begin
        rstn_in = 1'h0;
        ce_in = 1'h1;
        mdl = RST_WORD;
        held = RST_WORD;
        fails = 0;
        total_checks = 0;
        void'($urandom(32'hA893));
        repeat (10) @(negedge core_clk_in);
        rstn_in = 1'h1;
        @(negedge core_clk_in);
        check("reset_par", RST_WORD, par_data);
        check("reset_oe", RST_WORD, par_oe);
        check("reset_serial", RST_WORD, 8'({last_stage, cascade}));
        for (int i = 0; i < 12; i++) begin
            word = (i == 0) ? 8'h81 : (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : STAGES'($urandom());
            ctl.set_pin(PIN_OE, i[0]);
            check("par_oe", {STAGES{i[0]}}, par_oe);
            for (int b = STAGES - 1; b >= 0; b--) begin
                prev = mdl[STAGES-1];
                mdl = shift_in(mdl, word[b]);
                ctl.shift_rise(word[b]);
                check("last_stage", 8'(mdl[STAGES-1]), 8'(last_stage));
                check("cascade_hold", 8'(prev), 8'(cascade));
                check("par_held", held, par_data);
                ctl.set_pin(PIN_CLK, 1'h0);
                check("cascade", 8'(mdl[STAGES-1]), 8'(cascade));
            end
            ctl.set_pin(PIN_STROBE, 1'h1);
            check("par_word", word, par_data);
            check("par_pin", pin_exp(word, i[0]), par_pin);
            // one more bit while transparent
            mdl = shift_in(mdl, ~word[0]);
            ctl.shift_rise(~word[0]);
            check("par_follow", mdl, par_data);
            ctl.set_pin(PIN_CLK, 1'h0);
            ctl.set_pin(PIN_STROBE, 1'h0);
            ctl.shift_rise(word[1]);
            mdl = shift_in(mdl, word[1]);
            held = shift_in(word, ~word[0]);
            check("par_latched", held, par_data);
            ctl.set_pin(PIN_CLK, 1'h0);
            $display("word %0d done", i);
        end
        // frozen enable must hide the strobe pin
        ce_in = 1'h0;
        ctl.set_pin(PIN_STROBE, 1'h1);
        check("ce_freeze", held, par_data);
        ce_in = 1'h1;
        repeat (6) @(negedge core_clk_in);
        check("ce_resume", mdl, par_data);
        $display("enable test done");
        results();
    end
endmodule
`default_nettype wire
